// ### hdl/dtc_pkg.sv
package dtc_pkg;
    // register offsets on the special-function register port
    localparam logic [7:0] DTC_ADDR_CTRL   = 8'h88;
    localparam logic [7:0] DTC_ADDR_MODE   = 8'h89;
    localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8a;
    localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8b;
    localparam logic [7:0] DTC_ADDR_T0_HI  = 8'h8c;
    localparam logic [7:0] DTC_ADDR_T1_HI  = 8'h8d;
    // control register bit positions
    localparam int DTC_CTRL_T1_OVF = 7;
    localparam int DTC_CTRL_T1_RUN = 6;
    localparam int DTC_CTRL_T0_OVF = 5;
    localparam int DTC_CTRL_T0_RUN = 4;
    localparam int DTC_CTRL_X1_FLG = 3;
    localparam int DTC_CTRL_X1_TYP = 2;
    localparam int DTC_CTRL_X0_FLG = 1;
    localparam int DTC_CTRL_X0_TYP = 0;
    // mode register bit positions
    localparam int DTC_MODE_T1_GATE = 7;
    localparam int DTC_MODE_T1_SRC  = 6;
    localparam int DTC_MODE_T1_M_HI = 5;
    localparam int DTC_MODE_T1_M_LO = 4;
    localparam int DTC_MODE_T0_GATE = 3;
    localparam int DTC_MODE_T0_SRC  = 2;
    localparam int DTC_MODE_T0_M_HI = 1;
    localparam int DTC_MODE_T0_M_LO = 0;
    // reset values
    localparam logic [7:0] DTC_RST_CTRL = 8'h00;
    localparam logic [7:0] DTC_RST_MODE = 8'h00;
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;
    // peripheral cycle: six clock periods per count tick
    localparam int         DTC_TICK_PERIODS = 6;
    localparam logic [2:0] DTC_TICK_LAST    = 3'(DTC_TICK_PERIODS - 1);
    // prescaler width in mode 00
    localparam int         DTC_PRESC_BITS   = 5;
    localparam logic [7:0] DTC_PRESC_MASK   = 8'h1f;
    // operating modes of a unit
    typedef enum logic [1:0] {
        DTC_MODE_PRESC  = 2'h0,
        DTC_MODE_WIDE   = 2'h1,
        DTC_MODE_RELOAD = 2'h2,
        DTC_MODE_SPLIT  = 2'h3
    } dtc_mode_t;
endpackage

// ### hdl/dtc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - unit one rollover sets control bit 7 unless unit zero is in mode 11
// - unit zero rollover sets control bit 5
// - overflow flag clears on interrupt vectoring
// - control bit 6 runs unit one, or unit zero's high byte in mode 11
// - control bit 4 runs unit zero
// - irq one condition sets control bit 3
// - irq zero condition sets control bit 1
// - irq flag clears on service if edge
// - bit 2: zero low-level, one falling-edge
// - bit 0: zero low-level, one falling-edge
// - unit one gate needs irq-one pin high
// - unit zero gate needs irq-zero pin high
// - mode bit 6 picks unit one source
// - mode bit 2 picks unit zero source
// - unit one modes: presc, wide, reload, halt
// - unit one reload low byte from high
// - unit zero mode 00 prescaled high byte
// - unit zero reload low byte from high
// - unit zero mode 11 splits two timers
// - reset clears unit zero count bytes
// - timer ticks once per six clocks
// - counter samples pin, counts high-then-low
// - low overflow steps high, high sets flag
// - prescaler is low five bits, modulo 32
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [7:0] i_addr,          // register address
    input  wire logic       i_wr,            // register write strobe
    input  wire logic [7:0] i_wdata,         // register write data
    output logic      [7:0] o_rdata,         // register read data
    input  wire logic       i_ack_unit_one,  // vectoring to unit one
    input  wire logic       i_ack_unit_zero, // vectoring to unit zero
    input  wire logic       i_ack_irq_one,   // irq one serviced
    input  wire logic       i_ack_irq_zero,  // irq zero serviced
    input  wire logic       i_ext_irq_zero_pin,    // active-low pin
    input  wire logic       i_ext_irq_one_pin,     // active-low pin
    input  wire logic       i_unit_zero_count_pin, // event input
    input  wire logic       i_unit_one_count_pin,  // event input
    output logic            o_unit_zero_overflow_flag,
    output logic            o_unit_one_overflow_flag,
    output logic            o_ext_irq_zero_flag,
    output logic            o_ext_irq_one_flag,
    output logic            o_unit_one_ovf_pulse  // e.g. baud source
);
    logic [7:0] timer_control_flags;  // control and flags
    logic [7:0] timer_mode_select;    // gating, source, modes
    logic [7:0] timer_zero_low_byte;
    logic [7:0] timer_zero_high_byte;
    logic [7:0] timer_one_low_byte;
    logic [7:0] timer_one_high_byte;

    // two-stage synchronisers for the four pins
    logic [3:0] pin_meta;   // first stage, read only by second
    logic [3:0] pin_sync;   // second stage, safe to use
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
        end
        else
        begin
            pin_meta <= {i_unit_one_count_pin, i_unit_zero_count_pin,
                         i_ext_irq_one_pin, i_ext_irq_zero_pin};
            pin_sync <= pin_meta;
        end
    end

    logic irq0_pin;   // synchronised irq zero pin
    logic irq1_pin;   // synchronised irq one pin
    logic cnt0_pin;   // synchronised unit zero count pin
    logic cnt1_pin;   // synchronised unit one count pin
    assign irq0_pin = pin_sync[0];
    assign irq1_pin = pin_sync[1];
    assign cnt0_pin = pin_sync[2];
    assign cnt1_pin = pin_sync[3];

    // peripheral cycle divider: one tick every six clocks
    logic [2:0] tick_cnt;  // position inside the peripheral cycle
    logic       tick;      // one-cycle tick
    always_ff @(posedge i_clk)
    begin
        if (i_srst || tick_cnt == DTC_TICK_LAST)
            tick_cnt <= 3'h0;
        else
            tick_cnt <= 3'(tick_cnt + 3'h1);
    end
    assign tick = (tick_cnt == DTC_TICK_LAST);

    // pin samples taken once per peripheral cycle
    logic [3:0] samp_now;   // this peripheral cycle's samples
    logic [3:0] samp_prev;  // previous peripheral cycle's samples
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            samp_now  <= 4'hf;
            samp_prev <= 4'hf;
        end
        else if (tick)
        begin
            samp_now  <= pin_sync;
            samp_prev <= samp_now;
        end
    end

    // falling edges seen between consecutive samples, acted on at tick
    logic fall_cnt0;  // unit zero count pin fell
    logic fall_cnt1;  // unit one count pin fell
    logic fall_irq0;  // irq zero pin fell
    logic fall_irq1;  // irq one pin fell
    assign fall_cnt0 = tick && samp_prev[2] && !samp_now[2];
    assign fall_cnt1 = tick && samp_prev[3] && !samp_now[3];
    assign fall_irq0 = tick && samp_prev[0] && !samp_now[0];
    assign fall_irq1 = tick && samp_prev[1] && !samp_now[1];

    // decoded control fields
    logic      run0;    // unit zero run
    logic      run1;    // unit one run
    logic      unit_zero_pin_gating;   // unit zero pin gating
    logic      unit_one_pin_gating;   // unit one pin gating
    logic      src0;    // unit zero counts pin events
    logic      src1;    // unit one counts pin events
    dtc_mode_t mode0;   // unit zero mode
    dtc_mode_t mode1;   // unit one mode
    assign run0  = timer_control_flags[DTC_CTRL_T0_RUN];
    assign run1  = timer_control_flags[DTC_CTRL_T1_RUN];
    assign unit_zero_pin_gating = timer_mode_select[DTC_MODE_T0_GATE];
    assign unit_one_pin_gating = timer_mode_select[DTC_MODE_T1_GATE];
    assign src0  = timer_mode_select[DTC_MODE_T0_SRC];
    assign src1  = timer_mode_select[DTC_MODE_T1_SRC];
    assign mode0 = dtc_mode_t'({timer_mode_select[DTC_MODE_T0_M_HI],
                                timer_mode_select[DTC_MODE_T0_M_LO]});
    assign mode1 = dtc_mode_t'({timer_mode_select[DTC_MODE_T1_M_HI],
                                timer_mode_select[DTC_MODE_T1_M_LO]});

    // enables: run bit, optionally qualified by the irq pin level
    logic en0;       // unit zero may count
    logic en1;       // unit one may count
    logic split0;    // unit zero in split mode
    assign en0    = run0 && (!unit_zero_pin_gating || irq0_pin);
    assign split0 = (mode0 == DTC_MODE_SPLIT);

    // in split mode unit one loses its run bit to unit zero's high byte,
    // so unit one then runs free unless halted by its own mode 11
    assign en1 = split0 ? 1'b1
                        : (run1 && (!unit_one_pin_gating || irq1_pin));

    // count events per unit
    logic inc0_low;    // unit zero low byte step
    logic inc0_high;   // unit zero high byte step in split mode
    logic inc1_low;    // unit one low byte step
    assign inc0_low  = en0 && (src0 ? fall_cnt0 : tick);
    assign inc0_high = split0 && run1 && tick;
    assign inc1_low  = en1 && (mode1 != DTC_MODE_SPLIT)
                       && (src1 ? fall_cnt1 : tick);

    // register write strobes
    logic wr_ctrl;
    logic wr_mode;
    assign wr_ctrl = i_wr && (i_addr == DTC_ADDR_CTRL);
    assign wr_mode = i_wr && (i_addr == DTC_ADDR_MODE);

    logic ovf0;       // unit zero overflow pulse
    logic ovf1;       // unit one overflow pulse
    logic ovf0_high;  // unit zero high byte wrap in split mode
    logic ovf0_low;   // unit zero low byte overflow (drives unit zero flag in split mode)

    // unit zero bytes; reset clears both
    dtc_unit u_unit_zero (
        .i_clk       (i_clk),
        .i_srst      (i_srst),
        .i_rst_bytes (1'b0),
        .i_mode      (mode0),
        .i_low_inc   (inc0_low),
        .i_high_inc  (inc0_high),
        .i_split     (split0),
        .i_wr_low    (i_wr && (i_addr == DTC_ADDR_T0_LOW)),
        .i_wr_high   (i_wr && (i_addr == DTC_ADDR_T0_HI)),
        .i_wdata     (i_wdata),
        .o_low       (timer_zero_low_byte),
        .o_high      (timer_zero_high_byte),
        .o_low_ovf   (ovf0_low),
        .o_ovf       (ovf0_high)
    );

    // unit one bytes; never split
    dtc_unit u_unit_one (
        .i_clk       (i_clk),
        .i_srst      (i_srst),
        .i_rst_bytes (1'b0),
        .i_mode      (mode1),
        .i_low_inc   (inc1_low),
        .i_high_inc  (1'b0),
        .i_split     (1'b0),
        .i_wr_low    (i_wr && (i_addr == DTC_ADDR_T1_LOW)),
        .i_wr_high   (i_wr && (i_addr == DTC_ADDR_T1_HI)),
        .i_wdata     (i_wdata),
        .o_low       (timer_one_low_byte),
        .o_high      (timer_one_high_byte),
        .o_low_ovf   (),
        .o_ovf       (ovf1)
    );

    // split mode: low byte overflow drives unit zero flag,
    // high byte overflow borrows unit one's flag
    assign ovf0 = split0 ? ovf0_low : ovf0_high;

    logic set_tf1;  // unit one flag set source
    assign set_tf1 = split0 ? ovf0_high : ovf1;
    assign o_unit_one_ovf_pulse = ovf1;

    // external interrupt conditions by type
    logic x0_cond;  // irq zero condition seen
    logic x1_cond;  // irq one condition seen
    assign x0_cond = timer_control_flags[DTC_CTRL_X0_TYP]
                     ? fall_irq0 : !irq0_pin;
    assign x1_cond = timer_control_flags[DTC_CTRL_X1_TYP]
                     ? fall_irq1 : !irq1_pin;

    // control register: software writes, hardware sets win over clears
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            timer_control_flags <= DTC_RST_CTRL;
        else
        begin
            // plain software write of all bits first
            if (wr_ctrl)
                timer_control_flags <= i_wdata;
            // hardware clears on vectoring and service
            if (i_ack_unit_one)
                timer_control_flags[DTC_CTRL_T1_OVF] <= 1'b0;
            if (i_ack_unit_zero)
                timer_control_flags[DTC_CTRL_T0_OVF] <= 1'b0;
            if (i_ack_irq_one && timer_control_flags[DTC_CTRL_X1_TYP])
                timer_control_flags[DTC_CTRL_X1_FLG] <= 1'b0;
            if (i_ack_irq_zero && timer_control_flags[DTC_CTRL_X0_TYP])
                timer_control_flags[DTC_CTRL_X0_FLG] <= 1'b0;
            // hardware sets last so an event beats any clear
            if (set_tf1)
                timer_control_flags[DTC_CTRL_T1_OVF] <= 1'b1;
            if (ovf0)
                timer_control_flags[DTC_CTRL_T0_OVF] <= 1'b1;
            if (x1_cond)
                timer_control_flags[DTC_CTRL_X1_FLG] <= 1'b1;
            if (x0_cond)
                timer_control_flags[DTC_CTRL_X0_FLG] <= 1'b1;
        end
    end

    // mode register; changes are only safe with the unit stopped
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            timer_mode_select <= DTC_RST_MODE;
        else if (wr_mode)
            timer_mode_select <= i_wdata;
    end

    // read mux registered; unmapped addresses read zero
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_rdata <= 8'h00;
        else
        begin
            case (i_addr)
                DTC_ADDR_CTRL:   o_rdata <= timer_control_flags;
                DTC_ADDR_MODE:   o_rdata <= timer_mode_select;
                DTC_ADDR_T0_LOW: o_rdata <= timer_zero_low_byte;
                DTC_ADDR_T0_HI:  o_rdata <= timer_zero_high_byte;
                DTC_ADDR_T1_LOW: o_rdata <= timer_one_low_byte;
                DTC_ADDR_T1_HI:  o_rdata <= timer_one_high_byte;
                default:         o_rdata <= 8'h00;
            endcase
        end
    end

    // flags straight from the control register
    assign o_unit_one_overflow_flag  = timer_control_flags[DTC_CTRL_T1_OVF];
    assign o_unit_zero_overflow_flag = timer_control_flags[DTC_CTRL_T0_OVF];
    assign o_ext_irq_one_flag        = timer_control_flags[DTC_CTRL_X1_FLG];
    assign o_ext_irq_zero_flag       = timer_control_flags[DTC_CTRL_X0_FLG];
endmodule // dtc_top
`default_nettype wire

// ### hdl/dtc_unit.sv
`timescale 1ns/1ps
`default_nettype none
// one count unit: low and high byte, mode-dependent cascading
module dtc_unit
    import dtc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_rst_bytes,  // clear bytes on reset
    input  wire dtc_mode_t  i_mode,       // operating mode
    input  wire logic       i_low_inc,    // advance low byte
    input  wire logic       i_high_inc,   // advance high byte alone
    input  wire logic       i_split,      // high byte counts alone
    input  wire logic       i_wr_low,     // software write low byte
    input  wire logic       i_wr_high,    // software write high byte
    input  wire logic [7:0] i_wdata,      // write data
    output logic      [7:0] o_low,        // low count byte
    output logic      [7:0] o_high,       // high count byte
    output logic            o_low_ovf,    // low byte overflow pulse
    output logic            o_ovf         // unit overflow pulse
);
    logic low_wrap;   // low byte (or prescaler) wraps this cycle
    logic high_step;  // high byte advances this cycle
    logic high_wrap;  // high byte wraps this cycle

    // wrap detection depends on the mode
    always_comb
    begin
        if (i_mode == DTC_MODE_PRESC)
            low_wrap = i_low_inc &&
                       ((o_low & DTC_PRESC_MASK) == DTC_PRESC_MASK);
        else
            low_wrap = i_low_inc && (o_low == 8'hff);
        // cascade only in modes 00 and 01
        if (i_split)
            high_step = i_high_inc;
        else
            high_step = low_wrap && ((i_mode == DTC_MODE_PRESC) ||
                                     (i_mode == DTC_MODE_WIDE));
        high_wrap = high_step && (o_high == 8'hff);
    end

    // overflow pulses toward the flag logic
    always_comb
    begin
        o_low_ovf = low_wrap;
        if (i_split)
            o_ovf = high_wrap;
        else if (i_mode == DTC_MODE_RELOAD)
            o_ovf = low_wrap;
        else
            o_ovf = high_wrap;
    end

    // low byte: software write wins over counting
    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_rst_bytes)
            o_low <= DTC_RST_BYTE;
        else if (i_wr_low)
            o_low <= i_wdata;
        else if (i_low_inc)
        begin
            if (i_mode == DTC_MODE_PRESC)
                // upper three bits hold still, prescaler wraps at 32
                o_low <= {o_low[7:DTC_PRESC_BITS],
                          5'(o_low[4:0] + 5'h01)};
            else if (i_mode == DTC_MODE_RELOAD && low_wrap)
                o_low <= o_high;
            else
                o_low <= 8'(o_low + 8'h01);
        end
    end

    // high byte: reload leaves it untouched
    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_rst_bytes)
            o_high <= DTC_RST_BYTE;
        else if (i_wr_high)
            o_high <= i_wdata;
        else if (high_step)
            o_high <= 8'(o_high + 8'h01);
    end
endmodule // dtc_unit
`default_nettype wire

// ### verif/dtc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: count-pin source and interrupt service acks
module dtc_far_model (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_count_go,  // rise starts a three-fall burst
    input  wire logic       i_auto_ack,  // service pending irq flags
    input  wire logic [1:0] i_irq_flag,  // [0] irq zero, [1] irq one
    output logic            o_count_pin, // shared by both count inputs
    output var logic [1:0]  o_ack_irq    // service pulses
);
    logic [6:0] burst_cnt; // cycles into the burst, saturates

    // burst timer restarts on every rise of go
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !i_count_go)
            burst_cnt <= 7'h00;
        else if (burst_cnt != 7'h7f)
            burst_cnt <= burst_cnt + 7'h01;
    end

    // each level held two peripheral cycles so no sample misses it
    always_comb o_count_pin = (burst_cnt == 7'h00 || burst_cnt > 7'h48) ?
        1'b1 : (((burst_cnt - 7'h01) % 7'h18) >= 7'h0c);

    // one ack per pending flag, as a vectoring cpu would give
    always_ff @(posedge i_clk)
        o_ack_irq <= i_srst ? 2'h0 : (i_irq_flag & {2{i_auto_ack}} & ~o_ack_irq);
endmodule // dtc_far_model
`default_nettype wire

// ### verif/dtc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watcher for the two-unit timer block
module dtc_top_chk
    import dtc_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       i_ack_unit_one,
    input wire logic       i_ack_unit_zero,
    input wire logic       o_unit_zero_overflow_flag,
    input wire logic       o_unit_one_overflow_flag,
    input wire logic       o_ext_irq_zero_flag,
    input wire logic       o_ext_irq_one_flag,
    input wire logic       o_unit_one_ovf_pulse
);
    // unit zero split mode hands unit one's flag to unit zero's high byte,
    // so unit one's own pulse then must not be expected in the flag
    logic split_seen;  // last mode write chose unit zero mode 11
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            split_seen <= 1'b0;
        else if (i_wr && i_addr == DTC_ADDR_MODE)
            split_seen <= (i_wdata[1:0] == 2'h3);
    end

    // one domain, so clock and reset are given once
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // first edge out of reset shows cleared read data and overflow flags
    rst_clear_a: assert property ($fell(i_srst) |-> o_rdata == 8'h00 &&
        !o_unit_zero_overflow_flag && !o_unit_one_overflow_flag)
        else $error("read data or flag not clear after reset");
    // an overflow pulse lands in the flag one cycle on
    ovf1_set_a: assert property (o_unit_one_ovf_pulse && !split_seen |=>
        o_unit_one_overflow_flag)
        else $error("unit one flag missed an overflow");
    // flags are sticky until acked or written
    ovf1_hold_a: assert property (o_unit_one_overflow_flag &&
        !i_ack_unit_one && !i_wr |=> o_unit_one_overflow_flag)
        else $error("unit one flag dropped on its own");
    ovf0_hold_a: assert property (o_unit_zero_overflow_flag &&
        !i_ack_unit_zero && !i_wr |=> o_unit_zero_overflow_flag)
        else $error("unit zero flag dropped on its own");
    // vectoring clears the flag; only unit one's check excuses a colliding overflow pulse
    ovf1_ack_a: assert property (o_unit_one_overflow_flag && i_ack_unit_one &&
        !i_wr && !o_unit_one_ovf_pulse |=> !o_unit_one_overflow_flag)
        else $error("unit one flag survived its ack");
    ovf0_ack_a: assert property (o_unit_zero_overflow_flag &&
        i_ack_unit_zero && !i_wr |=> !o_unit_zero_overflow_flag)
        else $error("unit zero flag survived its ack");
    // control read shows the flag outputs at their bit places
    ctrl_view_a: assert property (i_addr == DTC_ADDR_CTRL |=>
        o_rdata[7] == $past(o_unit_one_overflow_flag) &&
        o_rdata[5] == $past(o_unit_zero_overflow_flag) &&
        o_rdata[3] == $past(o_ext_irq_one_flag) &&
        o_rdata[1] == $past(o_ext_irq_zero_flag))
        else $error("control read disagrees with flag outputs");
    // mode register reads back what was written
    mode_rw_a: assert property (i_wr && i_addr == DTC_ADDR_MODE ##1
        i_addr == DTC_ADDR_MODE && !i_wr |=> o_rdata == $past(i_wdata, 2))
        else $error("mode register lost a write");
endmodule // dtc_top_chk

bind dtc_top dtc_top_chk u_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_ack_unit_one(i_ack_unit_one), .i_ack_unit_zero(i_ack_unit_zero),
    .o_unit_zero_overflow_flag(o_unit_zero_overflow_flag),
    .o_unit_one_overflow_flag(o_unit_one_overflow_flag),
    .o_ext_irq_zero_flag(o_ext_irq_zero_flag),
    .o_ext_irq_one_flag(o_ext_irq_one_flag),
    .o_unit_one_ovf_pulse(o_unit_one_ovf_pulse));
`default_nettype wire

// ### verif/dtc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// register-level bench for the two-unit timer block
module dtc_top_tb_top;
    import dtc_pkg::*;
    logic       clk;          // 100 MHz
    logic       srst;         // sync reset, high
    logic [7:0] addr;         // register address
    logic       wr;           // write strobe
    logic [7:0] wdata;        // write data
    logic [7:0] rdata;        // read data
    logic [1:0] ack_unit;     // vectoring: [0] zero, [1] one
    logic [1:0] irq_pin;      // active-low pins, idle high
    logic [1:0] irq_flag;     // irq flag outputs
    logic [1:0] ovf_flag;     // overflow flag outputs
    logic [1:0] ack_irq;      // service acks from far model
    logic       cnt_pin;      // count pin for both units
    logic       go;           // starts a count burst
    logic       auto_ack;     // far model acks irqs
    logic       ovf_pulse;    // unit one overflow pulse
    int         fails;
    int         total_checks;
    // mode, lo addr, hi addr, lo, hi, run, exp lo, exp hi, exp flags,
    // bit0 gate pin level / bit1 count burst; each case runs 20 ticks
    logic [7:0] tbl [11][10] = '{
        '{8'h01, 8'h8a, 8'h8c, 8'hf0, 8'hff, 8'h10, 8'h04, 8'h00, 8'h20, 8'h01},
        '{8'h00, 8'h8a, 8'h8c, 8'hfe, 8'h00, 8'h10, 8'hf2, 8'h01, 8'h00, 8'h01},
        '{8'h02, 8'h8a, 8'h8c, 8'hf0, 8'hf0, 8'h10, 8'hf4, 8'hf0, 8'h20, 8'h01},
        '{8'h33, 8'h8a, 8'h8c, 8'h00, 8'hf0, 8'h50, 8'h14, 8'h04, 8'h80, 8'h01},
        '{8'h20, 8'h8b, 8'h8d, 8'hf0, 8'hf0, 8'h40, 8'hf4, 8'hf0, 8'h80, 8'h01},
        '{8'h30, 8'h8b, 8'h8d, 8'h12, 8'h34, 8'h40, 8'h12, 8'h34, 8'h00, 8'h01},
        '{8'h09, 8'h8a, 8'h8c, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h0a, 8'h00},
        '{8'h09, 8'h8a, 8'h8c, 8'h00, 8'h00, 8'h10, 8'h14, 8'h00, 8'h00, 8'h01},
        '{8'h05, 8'h8a, 8'h8c, 8'hfe, 8'h00, 8'h10, 8'h01, 8'h01, 8'h00, 8'h03},
        '{8'h50, 8'h8b, 8'h8d, 8'h10, 8'h00, 8'h40, 8'h13, 8'h00, 8'h00, 8'h03},
        '{8'h81, 8'h8b, 8'h8d, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h0a, 8'h00}};
    logic [7:0] probe [5] = '{8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8e};

    initial clk = 1'b0;
    always #5 clk = ~clk;

    dtc_top dut (.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wr(wr),
        .i_wdata(wdata), .o_rdata(rdata),
        .i_ack_unit_one(ack_unit[1]), .i_ack_unit_zero(ack_unit[0]),
        .i_ack_irq_one(ack_irq[1]), .i_ack_irq_zero(ack_irq[0]),
        .i_ext_irq_zero_pin(irq_pin[0]), .i_ext_irq_one_pin(irq_pin[1]),
        .i_unit_zero_count_pin(cnt_pin), .i_unit_one_count_pin(cnt_pin),
        .o_unit_zero_overflow_flag(ovf_flag[0]),
        .o_unit_one_overflow_flag(ovf_flag[1]),
        .o_ext_irq_zero_flag(irq_flag[0]), .o_ext_irq_one_flag(irq_flag[1]),
        .o_unit_one_ovf_pulse(ovf_pulse));

    dtc_far_model far (.i_clk(clk), .i_srst(srst), .i_count_go(go),
        .i_auto_ack(auto_ack), .i_irq_flag(irq_flag),
        .o_count_pin(cnt_pin), .o_ack_irq(ack_irq));

    // compare one byte, count it, report a miss at once
    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    // write strobe held for one full cycle, then an idle cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // read data is registered, so sample one cycle after the address
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check($sformatf("register %h", a), exp, rdata);
    endtask

    task automatic final_report;
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        srst = 1'b1;
        addr = 8'h00;
        wr = 1'b0;
        wdata = 8'h00;
        ack_unit = 2'h0;
        irq_pin = 2'h3;
        go = 1'b0;
        auto_ack = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        foreach (probe[j]) rd_reg(probe[j], 8'h00);
        wr_reg(8'h8e, 8'h5a);
        rd_reg(8'h8e, 8'h00);
        // run window is 120 enabled edges: exactly 20 ticks at any phase
        for (int i = 0; i < 11; i++)
        begin
            irq_pin = {2{tbl[i][9][0]}};
            wr_reg(DTC_ADDR_MODE, tbl[i][0]);
            wr_reg(tbl[i][1], tbl[i][3]);
            wr_reg(tbl[i][2], tbl[i][4]);
            rd_reg(DTC_ADDR_MODE, tbl[i][0]);
            wr_reg(DTC_ADDR_CTRL, tbl[i][5]);
            go = tbl[i][9][1];
            repeat (116) @(negedge clk);
            rd_reg(DTC_ADDR_CTRL, tbl[i][8] | tbl[i][5]);
            // stop by writing the flags back unchanged
            wr_reg(DTC_ADDR_CTRL, tbl[i][8]);
            go = 1'b0;
            rd_reg(tbl[i][1], tbl[i][6]);
            rd_reg(tbl[i][2], tbl[i][7]);
            ack_unit = 2'h3;
            @(negedge clk);
            ack_unit = 2'h0;
            rd_reg(DTC_ADDR_CTRL, tbl[i][8] & 8'h0f);
            irq_pin = 2'h3;
            repeat (6) @(negedge clk);
            wr_reg(DTC_ADDR_CTRL, 8'h00);
        end
        // per pin: falling edge then low level, serviced by the far side
        for (int u = 0; u < 2; u++)
        begin
            wr_reg(DTC_ADDR_CTRL, 8'h05);
            irq_pin[u] = 1'b0;
            repeat (24) @(negedge clk);
            irq_pin[u] = 1'b1;
            repeat (18) @(negedge clk);
            check("edge flag", 8'(1 << u), {6'h00, irq_flag});
            auto_ack = 1'b1;
            repeat (6) @(negedge clk);
            check("edge clear", 8'h00, {6'h00, irq_flag});
            wr_reg(DTC_ADDR_CTRL, 8'h00);
            irq_pin[u] = 1'b0;
            repeat (24) @(negedge clk);
            check("level flag", 8'(1 << u), {6'h00, irq_flag});
            irq_pin[u] = 1'b1;
            auto_ack = 1'b0;
            repeat (6) @(negedge clk);
            wr_reg(DTC_ADDR_CTRL, 8'h00);
        end
        final_report();
    end

    // hang guard, well beyond the roughly 1780 cycles the sequence needs
    initial
    begin
        repeat (6000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule // dtc_top_tb_top
`default_nettype wire
